// ===== logic/dmrm_pkg.sv
// Constants for the drive register map: addresses, fields, codes.
// Assumes a neighbouring framer delivers decoded register requests.
package dmrm_pkg;
  // Special register addresses
  localparam logic [15:0] DMRM_CMD_ADDR   = 16'h2000;
  localparam logic [15:0] DMRM_FREQ_ADDR  = 16'h2001;
  localparam logic [15:0] DMRM_CTRL_ADDR  = 16'h2002;
  localparam logic [15:0] DMRM_WARN_ADDR  = 16'h2100;
  localparam logic [15:0] DMRM_STAT_ADDR  = 16'h2101;
  localparam logic [7:0]  DMRM_CMD_GROUP  = 8'h20;
  localparam logic [7:0]  DMRM_STAT_GROUP = 8'h21;
  // Function codes
  localparam logic [7:0]  DMRM_FN_READ    = 8'h03;
  localparam logic [7:0]  DMRM_FN_WR1     = 8'h06;
  localparam logic [7:0]  DMRM_FN_WRN     = 8'h10;
  localparam logic [7:0]  DMRM_MAX_WORDS  = 8'h14;
  // Exception codes
  localparam logic [7:0]  DMRM_EXC_NONE   = 8'h00;
  localparam logic [7:0]  DMRM_EXC_FUNC   = 8'h01;
  localparam logic [7:0]  DMRM_EXC_ADDR   = 8'h02;
  localparam logic [7:0]  DMRM_EXC_COUNT  = 8'h03;
  // Command word fields
  localparam int DMRM_RUN_LSB   = 0;
  localparam int DMRM_DIR_LSB   = 4;
  localparam int DMRM_ACC_LSB   = 6;
  localparam int DMRM_SPD_LSB   = 8;
  localparam int DMRM_F0611_BIT = 12;
  localparam int DMRM_SRC_LSB   = 13;
  // Control word fields
  localparam int DMRM_EF_BIT    = 0;
  localparam int DMRM_RST_BIT   = 1;
  localparam int DMRM_BB_BIT    = 2;
  // Frame check
  localparam logic [15:0] DMRM_CRC_INIT   = 16'hffff;
  localparam logic [15:0] DMRM_CRC_POLY   = 16'ha001;
  // Reset values
  localparam logic [15:0] DMRM_WORD_RST   = 16'h0000;
endpackage

// ===== logic/dmrm_regmap.sv
// Drive register map behind a decoded Modbus request port, plus RTU frame check.
// Assumes framer, status sources and parameter store run on mclk.
// How it works
// - Parameter address splits into group and index
// - Bits 7:6 choose acceleration time set
// - Bits 11:8 choose master or stage speed
// - Bit 12 set enables the linked function
// - Bits 14:13 set or change operation source
// - Control word: external fault, reset, output block
// - Status bits 1:0 report run state
// - Status bits 4:3 report direction
// - Frame check from ones, reflected, low first
// - Single write echoes; multiple write max 20
module dmrm_regmap
  import dmrm_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        req_valid,
  input  wire logic [7:0]  req_func,
  input  wire logic [15:0] req_addr,
  input  wire logic [15:0] req_data,
  input  wire logic [7:0]  req_count,
  output logic             rsp_valid_q,
  output logic [7:0]       rsp_func_q,
  output logic [15:0]      rsp_addr_q,
  output logic [15:0]      rsp_data_q,
  output logic [7:0]       rsp_exc_q,
  output logic             param_wr_q,
  output logic [7:0]       param_group_q,
  output logic [7:0]       param_index_q,
  output logic [15:0]      param_wdata_q,
  output logic             param_rd,
  output logic [7:0]       param_rd_group,
  output logic [7:0]       param_rd_index,
  input  wire logic [15:0] param_rdata,
  output logic             run_stb_q,
  output logic [1:0]       run_code_q,
  output logic             dir_stb_q,
  output logic [1:0]       dir_code_q,
  output logic [1:0]       accel_set_q,
  output logic [3:0]       speed_sel_q,
  output logic             func0611_stb_q,
  output logic             op_src_stb_q,
  output logic [1:0]       op_src_code_q,
  output logic [15:0]      freq_setpoint_q,
  output logic             external_fault_input_q,
  output logic             fault_reset_stb_q,
  output logic             output_block_stb_q,
  input  wire logic [7:0]  warn_code,
  input  wire logic [7:0]  error_code,
  input  wire logic [1:0]  run_state,
  input  wire logic        jog_active,
  input  wire logic [1:0]  run_direction,
  input  wire logic        crc_clear,
  input  wire logic        crc_byte_valid,
  input  wire logic [7:0]  crc_byte,
  output logic [15:0]      crc_q,
  output logic [7:0]       crc_tx_first,
  output logic [7:0]       crc_tx_second
);

  logic        rsp_valid_d;
  logic [7:0]  rsp_func_d;
  logic [15:0] rsp_addr_d;
  logic [15:0] rsp_data_d;
  logic [7:0]  rsp_exc_d;
  logic        param_wr_d;
  logic [7:0]  param_group_d;
  logic [7:0]  param_index_d;
  logic [15:0] param_wdata_d;
  logic        run_stb_d;
  logic [1:0]  run_code_d;
  logic        dir_stb_d;
  logic [1:0]  dir_code_d;
  logic [1:0]  accel_set_d;
  logic [3:0]  speed_sel_d;
  logic        func0611_stb_d;
  logic        op_src_stb_d;
  logic [1:0]  op_src_code_d;
  logic [15:0] freq_setpoint_d;
  logic        ext_fault_d;
  logic        fault_reset_stb_d;
  logic        output_block_stb_d;
  logic [15:0] crc_d;
  logic        is_special;
  logic        is_write;
  logic [15:0] crc_stage [0:8];
  logic [15:0] status_word;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  assign is_special = (req_addr[15:8] == DMRM_CMD_GROUP) || (req_addr[15:8] == DMRM_STAT_GROUP);
  assign is_write   = (req_func == DMRM_FN_WR1) ||
                      ((req_func == DMRM_FN_WRN) && (req_count != 8'h00) && (req_count <= DMRM_MAX_WORDS));
  assign status_word = {11'h000, run_direction, jog_active, run_state};

  // Parameter reads answered from the store in the same cycle
  assign param_rd       = req_valid && (req_func == DMRM_FN_READ) && !is_special;
  assign param_rd_group = req_addr[15:8];
  assign param_rd_index = req_addr[7:0];

  // Eight reflected shift steps per byte
  assign crc_stage[0] = crc_q ^ {8'h00, crc_byte};
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_crc
      assign crc_stage[gi+1] = crc_stage[gi][0] ? ((crc_stage[gi] >> 1) ^ DMRM_CRC_POLY)
                                                 : (crc_stage[gi] >> 1);
    end
  endgenerate
  assign crc_tx_first  = crc_q[7:0];
  assign crc_tx_second = crc_q[15:8];

  always_comb begin
    rsp_valid_d        = 1'b0;
    rsp_func_d         = rsp_func_q;
    rsp_addr_d         = rsp_addr_q;
    rsp_data_d         = rsp_data_q;
    rsp_exc_d          = rsp_exc_q;
    param_wr_d         = 1'b0;
    param_group_d      = param_group_q;
    param_index_d      = param_index_q;
    param_wdata_d      = param_wdata_q;
    run_stb_d          = 1'b0;
    run_code_d         = run_code_q;
    dir_stb_d          = 1'b0;
    dir_code_d         = dir_code_q;
    accel_set_d        = accel_set_q;
    speed_sel_d        = speed_sel_q;
    func0611_stb_d     = 1'b0;
    op_src_stb_d       = 1'b0;
    op_src_code_d      = op_src_code_q;
    freq_setpoint_d    = freq_setpoint_q;
    ext_fault_d        = external_fault_input_q;
    fault_reset_stb_d  = 1'b0;
    output_block_stb_d = 1'b0;
    crc_d              = crc_q;
    if (crc_clear) begin
      crc_d = DMRM_CRC_INIT;
    end else if (crc_byte_valid) begin
      crc_d = crc_stage[8];
    end
    if (req_valid) begin
      rsp_valid_d = 1'b1;
      rsp_func_d  = req_func;
      rsp_addr_d  = req_addr;
      rsp_data_d  = req_data;
      rsp_exc_d   = DMRM_EXC_NONE;
      if (req_func == DMRM_FN_READ) begin
        if (!is_special) begin
          rsp_data_d = param_rdata;
        end else if (req_addr == DMRM_WARN_ADDR) begin
          rsp_data_d = {warn_code, error_code};
        end else if (req_addr == DMRM_STAT_ADDR) begin
          rsp_data_d = status_word;
        end else begin
          rsp_data_d = DMRM_WORD_RST;
          rsp_exc_d  = DMRM_EXC_ADDR;
        end
      end else if (is_write) begin
        if (!is_special) begin
          param_wr_d    = 1'b1;
          param_group_d = req_addr[15:8];
          param_index_d = req_addr[7:0];
          param_wdata_d = req_data;
        end else if (req_addr == DMRM_CMD_ADDR) begin
          run_code_d     = req_data[DMRM_RUN_LSB +: 2];
          run_stb_d      = (req_data[DMRM_RUN_LSB +: 2] != 2'b00);
          dir_code_d     = req_data[DMRM_DIR_LSB +: 2];
          dir_stb_d      = (req_data[DMRM_DIR_LSB +: 2] != 2'b00);
          accel_set_d    = req_data[DMRM_ACC_LSB +: 2];
          speed_sel_d    = req_data[DMRM_SPD_LSB +: 4];
          func0611_stb_d = req_data[DMRM_F0611_BIT];
          op_src_code_d  = req_data[DMRM_SRC_LSB +: 2];
          op_src_stb_d   = (req_data[DMRM_SRC_LSB +: 2] != 2'b00);
        end else if (req_addr == DMRM_FREQ_ADDR) begin
          freq_setpoint_d = req_data;
        end else if (req_addr == DMRM_CTRL_ADDR) begin
          ext_fault_d        = req_data[DMRM_EF_BIT];
          fault_reset_stb_d  = req_data[DMRM_RST_BIT];
          output_block_stb_d = req_data[DMRM_BB_BIT];
        end else begin
          rsp_exc_d = DMRM_EXC_ADDR;
        end
      end else if (req_func == DMRM_FN_WRN) begin
        rsp_exc_d = DMRM_EXC_COUNT;
      end else begin
        rsp_exc_d = DMRM_EXC_FUNC;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_valid_q            <= 1'b0;
      rsp_func_q             <= 8'h00;
      rsp_addr_q             <= DMRM_WORD_RST;
      rsp_data_q             <= DMRM_WORD_RST;
      rsp_exc_q              <= DMRM_EXC_NONE;
      param_wr_q             <= 1'b0;
      param_group_q          <= 8'h00;
      param_index_q          <= 8'h00;
      param_wdata_q          <= DMRM_WORD_RST;
      run_stb_q              <= 1'b0;
      run_code_q             <= 2'h0;
      dir_stb_q              <= 1'b0;
      dir_code_q             <= 2'h0;
      accel_set_q            <= 2'h0;
      speed_sel_q            <= 4'h0;
      func0611_stb_q         <= 1'b0;
      op_src_stb_q           <= 1'b0;
      op_src_code_q          <= 2'h0;
      freq_setpoint_q        <= DMRM_WORD_RST;
      external_fault_input_q <= 1'b0;
      fault_reset_stb_q      <= 1'b0;
      output_block_stb_q     <= 1'b0;
      crc_q                  <= DMRM_CRC_INIT;
    end else begin
      rsp_valid_q            <= rsp_valid_d;
      rsp_func_q             <= rsp_func_d;
      rsp_addr_q             <= rsp_addr_d;
      rsp_data_q             <= rsp_data_d;
      rsp_exc_q              <= rsp_exc_d;
      param_wr_q             <= param_wr_d;
      param_group_q          <= param_group_d;
      param_index_q          <= param_index_d;
      param_wdata_q          <= param_wdata_d;
      run_stb_q              <= run_stb_d;
      run_code_q             <= run_code_d;
      dir_stb_q              <= dir_stb_d;
      dir_code_q             <= dir_code_d;
      accel_set_q            <= accel_set_d;
      speed_sel_q            <= speed_sel_d;
      func0611_stb_q         <= func0611_stb_d;
      op_src_stb_q           <= op_src_stb_d;
      op_src_code_q          <= op_src_code_d;
      freq_setpoint_q        <= freq_setpoint_d;
      external_fault_input_q <= ext_fault_d;
      fault_reset_stb_q      <= fault_reset_stb_d;
      output_block_stb_q     <= output_block_stb_d;
      crc_q                  <= crc_d;
    end
  end

  // Checks

  sequence s_cmd_write;
    req_valid && req_func == DMRM_FN_WR1 && req_addr == DMRM_CMD_ADDR;
  endsequence
  sequence s_ctrl_write;
    req_valid && req_func == DMRM_FN_WR1 && req_addr == DMRM_CTRL_ADDR;
  endsequence

  param_split_a: assert property (req_valid && is_write && !is_special |=>
    param_wr_q && param_group_q == $past(req_addr[15:8]) && param_index_q == $past(req_addr[7:0]))
    else $error("parameter address split wrong");
  accel_set_a: assert property (s_cmd_write |=> accel_set_q == $past(req_data[7:6]))
    else $error("accel set not taken");
  speed_sel_a: assert property (s_cmd_write ##1 !req_valid [*2] |-> speed_sel_q == $past(req_data[11:8], 2))
    else $error("speed select not held");
  func_enable_a: assert property (s_cmd_write |=> func0611_stb_q == $past(req_data[12]))
    else $error("linked function enable wrong");
  op_source_a: assert property (s_cmd_write |=> op_src_stb_q == ($past(req_data[14:13]) != 2'b00))
    else $error("operation source strobe wrong");
  ctrl_word_a: assert property (s_ctrl_write |=> external_fault_input_q == $past(req_data[0]) &&
    fault_reset_stb_q == $past(req_data[1]) && output_block_stb_q == $past(req_data[2]))
    else $error("control word effect wrong");
  run_status_a: assert property (req_valid && req_func == DMRM_FN_READ && req_addr == DMRM_STAT_ADDR |=>
    rsp_data_q[1:0] == $past(run_state) && rsp_exc_q == DMRM_EXC_NONE)
    else $error("run state not reported");
  dir_status_a: assert property (req_valid && req_func == DMRM_FN_READ && req_addr == DMRM_STAT_ADDR |=>
    rsp_data_q[4:3] == $past(run_direction) && rsp_data_q[15:5] == 11'h000)
    else $error("direction not reported");
  run_request_a: assert property (s_cmd_write |=> run_stb_q == ($past(req_data[1:0]) != 2'b00) &&
    dir_code_q == $past(req_data[5:4]))
    else $error("run or direction request wrong");
  freq_word_a: assert property (req_valid && is_write && req_addr == DMRM_FREQ_ADDR |=>
    freq_setpoint_q == $past(req_data))
    else $error("frequency setpoint not stored");
  crc_start_a: assert property (crc_clear |=> crc_q == DMRM_CRC_INIT && crc_tx_first == 8'hff)
    else $error("frame check start wrong");
  write_echo_a: assert property (req_valid && req_func == DMRM_FN_WR1 && !is_special |=> rsp_valid_q &&
    rsp_addr_q == $past(req_addr) && rsp_data_q == $past(req_data) && rsp_exc_q == DMRM_EXC_NONE)
    else $error("single write not echoed");
  word_limit_a: assert property (req_valid && req_func == DMRM_FN_WRN && req_count > DMRM_MAX_WORDS |=>
    rsp_exc_q == DMRM_EXC_COUNT && !param_wr_q)
    else $error("over-long multiple write accepted");

endmodule // dmrm_regmap

// ===== test/dmrm_master_model.sv
// Modbus master model: issues decoded request words to the register map.
// Assumes mclk from the bench; requests launch on rising edges.
module dmrm_master_model (
  input  wire logic        mclk,
  output logic             req_valid,
  output logic [7:0]       req_func,
  output logic [15:0]      req_addr,
  output logic [15:0]      req_data,
  output logic [7:0]       req_count
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req_valid = 1'b0;
    req_func  = 8'h00;
    req_addr  = 16'h0000;
    req_data  = 16'h0000;
    req_count = 8'h00;
  end
  // One word per request, held for exactly the taking edge
  task automatic send(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d, input logic [7:0] c);
    @(posedge mclk);
    req_valid <= 1'b1;
    req_func  <= f;
    req_addr  <= a;
    req_data  <= d;
    req_count <= c;
    @(posedge mclk);
    req_valid <= 1'b0;
    // Released address and data lines show the inverse
    req_addr  <= ~a;
    req_data  <= ~d;
  endtask
endmodule // dmrm_master_model

// ===== test/drive_modbus_register_map_tb.sv
// Self-checking bench for the drive register map.
// Assumes the master model drives requests; bench plays parameter store and status.
module drive_modbus_register_map_tb import dmrm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, reset_n, crc_clear, crc_byte_valid, jog_active;
  logic req_valid, rsp_valid_q, param_wr_q, param_rd, run_stb_q, dir_stb_q, func0611_stb_q, op_src_stb_q;
  logic external_fault_input_q, fault_reset_stb_q, output_block_stb_q;
  logic [7:0] req_func, req_count, rsp_func_q, rsp_exc_q, param_group_q, param_index_q, param_rd_group;
  logic [7:0] param_rd_index, warn_code, error_code, crc_byte, crc_tx_first, crc_tx_second;
  logic [15:0] req_addr, req_data, rsp_addr_q, rsp_data_q, param_wdata_q, param_rdata, freq_setpoint_q, crc_q;
  logic [1:0] run_code_q, dir_code_q, accel_set_q, op_src_code_q, run_state, run_direction;
  logic [3:0] speed_sel_q;
  int n_fail = 0;
  int checks_done = 0;
  dmrm_master_model dmrm_master_model_i (.mclk, .req_valid, .req_func, .req_addr, .req_data, .req_count);
  dmrm_regmap dmrm_regmap_i (.mclk, .reset_n, .req_valid, .req_func, .req_addr, .req_data, .req_count,
    .rsp_valid_q, .rsp_func_q, .rsp_addr_q, .rsp_data_q, .rsp_exc_q, .param_wr_q, .param_group_q,
    .param_index_q, .param_wdata_q, .param_rd, .param_rd_group, .param_rd_index, .param_rdata, .run_stb_q,
    .run_code_q, .dir_stb_q, .dir_code_q, .accel_set_q, .speed_sel_q, .func0611_stb_q, .op_src_stb_q,
    .op_src_code_q, .freq_setpoint_q, .external_fault_input_q, .fault_reset_stb_q, .output_block_stb_q,
    .warn_code, .error_code, .run_state, .jog_active, .run_direction, .crc_clear, .crc_byte_valid,
    .crc_byte, .crc_q, .crc_tx_first, .crc_tx_second);
  // Parameter store answers in the request cycle
  assign param_rdata = param_rd ? ({param_rd_index, param_rd_group} ^ 16'hc3c3) : 16'h0bad;
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic req(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d, input logic [7:0] c,
                     input logic [7:0] exc);
    dmrm_master_model_i.send(f, a, d, c);
    #1;
    chk("rsp valid", 16'(rsp_valid_q), 16'h0001);
    chk("rsp exc", 16'(rsp_exc_q), 16'(exc));
    chk("rsp func", 16'(rsp_func_q), 16'(f));
    chk("rsp addr", rsp_addr_q, a);
  endtask
  task automatic t_cmd;
    logic [15:0] d;
    for (int i = 0; i < 4; i++) begin
      d = {1'b0, i[1:0], i[0], 4'(i * 5), i[1:0], i[1:0], 2'b00, i[1:0]};
      req(DMRM_FN_WR1, DMRM_CMD_ADDR, d, 8'h01, DMRM_EXC_NONE);
      chk("echo data", rsp_data_q, d);
      chk("run stb", 16'(run_stb_q), 16'(i != 0));
      chk("dir stb", 16'(dir_stb_q), 16'(i != 0));
      chk("accel", 16'(accel_set_q), 16'(i));
      chk("speed", 16'(speed_sel_q), 16'(i * 5));
      chk("f0611", 16'(func0611_stb_q), 16'(i[0]));
      chk("src stb", 16'(op_src_stb_q), 16'(i != 0));
      if (i != 0) begin
        chk("codes", {10'h0, run_code_q, dir_code_q, op_src_code_q}, 16'({3{i[1:0]}}));
      end
    end
    @(posedge mclk);
    #1;
    chk("src pulse end", 16'(op_src_stb_q), 16'h0000);
    $display("test command done");
  endtask
  task automatic t_ctrl;
    req(DMRM_FN_WR1, DMRM_FREQ_ADDR, 16'hea60, 8'h01, DMRM_EXC_NONE);
    chk("freq", freq_setpoint_q, 16'hea60);
    req(DMRM_FN_WR1, DMRM_CTRL_ADDR, 16'h0007, 8'h01, DMRM_EXC_NONE);
    chk("ctl set", {13'h0, output_block_stb_q, fault_reset_stb_q, external_fault_input_q}, 16'h0007);
    req(DMRM_FN_WR1, DMRM_CTRL_ADDR, 16'h0000, 8'h01, DMRM_EXC_NONE);
    chk("ctl clr", {13'h0, output_block_stb_q, fault_reset_stb_q, external_fault_input_q}, 16'h0000);
    $display("test control done");
  endtask
  task automatic t_stat;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      warn_code     <= 8'(8'h10 + i);
      error_code    <= 8'(8'h80 + i);
      run_state     <= i[1:0];
      jog_active    <= i[0];
      run_direction <= ~i[1:0];
      req(DMRM_FN_READ, DMRM_WARN_ADDR, 16'h0000, 8'h01, DMRM_EXC_NONE);
      chk("warn err", rsp_data_q, {8'(8'h10 + i), 8'(8'h80 + i)});
      req(DMRM_FN_READ, DMRM_STAT_ADDR, 16'h0000, 8'h01, DMRM_EXC_NONE);
      chk("status", {11'h0, rsp_data_q[4:0]}, {11'h0, ~i[1:0], i[0], i[1:0]});
    end
    $display("test status done");
  endtask
  task automatic t_param;
    req(DMRM_FN_READ, 16'h0401, 16'h0000, 8'h01, DMRM_EXC_NONE);
    chk("param rd", rsp_data_q, 16'h0104 ^ 16'hc3c3);
    req(DMRM_FN_WRN, 16'h04ff, 16'h1388, 8'h14, DMRM_EXC_NONE);
    chk("param wr", {param_group_q, param_index_q}, 16'h04ff);
    chk("param data", param_wdata_q, 16'h1388);
    chk("param pulse", 16'(param_wr_q), 16'h0001);
    req(DMRM_FN_READ, DMRM_CMD_ADDR, 16'h0000, 8'h01, DMRM_EXC_ADDR);
    chk("refused data", rsp_data_q, DMRM_WORD_RST);
    req(DMRM_FN_WR1, DMRM_STAT_ADDR, 16'h1234, 8'h01, DMRM_EXC_ADDR);
    req(DMRM_FN_WRN, 16'h0500, 16'h0fa0, 8'h15, DMRM_EXC_COUNT);
    req(DMRM_FN_WRN, 16'h0500, 16'h0fa0, 8'h00, DMRM_EXC_COUNT);
    req(8'h05, 16'h0500, 16'h0fa0, 8'h01, DMRM_EXC_FUNC);
    $display("test parameter done");
  endtask
  task automatic t_crc;
    logic [7:0] b [6];
    b = '{8'h01, 8'h06, 8'h01, 8'h00, 8'h17, 8'h70};
    @(posedge mclk);
    crc_clear <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      crc_clear      <= 1'b0;
      crc_byte_valid <= 1'b1;
      crc_byte       <= b[i];
    end
    @(posedge mclk);
    crc_byte_valid <= 1'b0;
    crc_byte       <= 8'h8f;
    #1;
    chk("crc order", {crc_tx_first, crc_tx_second}, 16'h8622);
    chk("crc reg", crc_q, 16'h2286);
    $display("test crc done");
  endtask
  task automatic t_reset;
    @(posedge mclk);
    reset_n <= 1'b0;
    #1;
    chk("rst freq", freq_setpoint_q, DMRM_WORD_RST);
    chk("rst speed", {12'h000, speed_sel_q}, 16'h0000);
    chk("rst accel", 16'(accel_set_q), 16'h0000);
    chk("rst crc", crc_q, DMRM_CRC_INIT);
    @(posedge mclk);
    reset_n <= 1'b1;
    req(DMRM_FN_WR1, DMRM_FREQ_ADDR, 16'h1388, 8'h01, DMRM_EXC_NONE);
    chk("freq after rst", freq_setpoint_q, 16'h1388);
    $display("test reset done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #(5000 * 50);
    n_fail++;
    summarize();
  end
  initial begin
    reset_n = 1'b0;
    {crc_clear, crc_byte_valid, jog_active, crc_byte} = 11'h000;
    {warn_code, error_code, run_state, run_direction} = 20'h00000;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    t_cmd();
    t_ctrl();
    t_stat();
    t_param();
    t_crc();
    t_reset();
    summarize();
  end
endmodule // drive_modbus_register_map_tb
